// ==== bench/ssc_host.sv ====
/*
 * Host-side serial master model: frames of up to 16 bits, LSB first.
 * Assumes calls start just after a falling system clock edge; half period 80 ns.
 */
`timescale 1ns/1ps
module ssc_host (
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire spi_miso
);
    // link idles with clock low and chip deselected
    initial begin
        spi_clk = 1'h0;
        spi_cs_n = 1'h1;
        spi_mosi = 1'h0;
    end

    // one frame: data set after each rise, answer taken at each fall
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        spi_cs_n = 1'h0;
        #80;
        for (int k = 0; k < nbits; k++) begin
            spi_clk = 1'h1;
            spi_mosi = tx[k];
            #80;
            rx[k] = spi_miso;
            spi_clk = 1'h0;
            #80;
        end
        spi_cs_n = 1'h1;
        // no pull on the data line, so the released level must not look stable
        spi_mosi = ~spi_mosi;
        #80;
    endtask
endmodule // ssc_host

// ==== bench/ssc_mode_supply_sva.sv ====
/*
 * Port-level checker for the mode-and-supply block, bound into it.
 * Assumes one clock domain with synchronous active-high reset.
 */
`timescale 1ns/1ps
module ssc_mode_supply_sva #(
    parameter RESET_PULSE_CYCLES = 1000,
    parameter CNT_W = 16
) (
    input wire clk,
    input wire reset,
    input wire spi_clk,
    input wire spi_cs_n,
    input wire spi_mosi,
    input wire spi_miso,
    input wire dev_mode_pin,
    input wire overvoltage_pin,
    input wire overtemp_pin,
    input wire restart_request_pin,
    input wire failsafe_select_pin,
    input wire flag_clear,
    input wire reset_output_low,
    input wire secondary_supply_on,
    input wire [1:0] reset_threshold_select,
    input wire primary_overvoltage_flag,
    input wire spi_failure_flag,
    input wire [2:0] mode_state
);
    localparam int PULSE_MIN = RESET_PULSE_CYCLES - 4;
    localparam int PULSE_MAX = RESET_PULSE_CYCLES + 4;
    logic [CNT_W-1:0] rst_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // cycles spent in restart; the run is too long to unroll as a repetition
    always_ff @(posedge clk) begin
        if (reset || mode_state != 3'h4) rst_cnt <= '0;
        else rst_cnt <= rst_cnt + 1'h1;
    end

    reset_values_a: assert property (disable iff (1'h0) reset |=> !reset_output_low && !secondary_supply_on
        && reset_threshold_select == 2'h0 && !primary_overvoltage_flag && !spi_failure_flag && mode_state == 3'h0)
        else $error("outputs not at reset values");
    ov_flag_set_a: assert property ($rose(overvoltage_pin) |-> ##[2:6] primary_overvoltage_flag)
        else $error("overvoltage flag not set");
    ov_flag_hold_a: assert property (primary_overvoltage_flag && !flag_clear |=> primary_overvoltage_flag)
        else $error("overvoltage flag lost");
    restart_supply_off_a: assert property (mode_state[2] && $stable(mode_state) && $past(mode_state, 2) == mode_state
        |-> !secondary_supply_on) else $error("supply on in restart or fail-safe");
    overtemp_off_a: assert property ($rose(overtemp_pin) |-> ##[3:7] !secondary_supply_on)
        else $error("supply not off after overtemperature");
    restart_exit_a: assert property ($fell(mode_state == 3'h4) |-> mode_state == 3'h1
        && rst_cnt >= PULSE_MIN && rst_cnt <= PULSE_MAX) else $error("restart exit wrong");
    // reset output is released one cycle before restart is left, so look one sample back
    restart_keep_a: assert property (mode_state == 3'h4 && $past(mode_state) == 3'h4
        |-> $stable(reset_threshold_select) && !$past(reset_output_low)) else $error("restart changed threshold");
    reset_pulse_a: assert property ($rose(reset_output_low) |-> $past(reset_output_low, 8) == 1'h0)
        else $error("reset output pulse too short");
    stop_no_sleep_a: assert property (mode_state == 3'h3 |=> mode_state != 3'h2)
        else $error("stop went straight to sleep");
    fail_flag_hold_a: assert property (spi_failure_flag && !flag_clear |=> spi_failure_flag)
        else $error("serial failure flag lost");
endmodule // ssc_mode_supply_sva

bind ssc_mode_supply ssc_mode_supply_sva #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES), .CNT_W(CNT_W)) chk (
    .clk(clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .dev_mode_pin(dev_mode_pin), .overvoltage_pin(overvoltage_pin), .overtemp_pin(overtemp_pin),
    .restart_request_pin(restart_request_pin), .failsafe_select_pin(failsafe_select_pin),
    .flag_clear(flag_clear), .reset_output_low(reset_output_low), .secondary_supply_on(secondary_supply_on),
    .reset_threshold_select(reset_threshold_select), .primary_overvoltage_flag(primary_overvoltage_flag),
    .spi_failure_flag(spi_failure_flag), .mode_state(mode_state));

// ==== bench/tb.sv ====
/*
 * Self-checking bench for the mode-and-supply block: register table, events, mode moves.
 * Assumes the host model and checker are compiled with it; pins change at falling clk.
 */
`timescale 1ns/1ps
module tb;
    typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] keep; logic sup; logic [1:0] thr;} ssc_row_t;
    logic clk, reset, dev_mode_pin, overvoltage_pin, overtemp_pin, restart_request_pin, failsafe_select_pin;
    logic flag_clear;
    wire spi_clk, spi_cs_n, spi_mosi, spi_miso, reset_output_low, secondary_supply_on;
    wire primary_overvoltage_flag, spi_failure_flag;
    wire [1:0] reset_threshold_select;
    wire [2:0] mode_state;
    logic [15:0] rx;
    logic [7:0] rb;
    logic [7:0] shadow [0:127];
    int fail_count = 0;
    int cmp_count = 0;
    int lows;
    // address, data written, value kept, supply output, threshold output
    ssc_row_t rows [0:8] = '{'{7'h1f, 8'ha5, 8'ha5, 1'h0, 2'h0}, '{7'h1e, 8'h5a, 8'h5a, 1'h0, 2'h0},
        '{7'h05, 8'haa, 8'h00, 1'h0, 2'h0}, '{7'h02, 8'h40, 8'h40, 1'h0, 2'h0},
        '{7'h01, 8'h3f, 8'h1f, 1'h1, 2'h3}, '{7'h01, 8'h08, 8'h08, 1'h1, 2'h0},
        '{7'h01, 8'h11, 8'h11, 1'h1, 2'h1}, '{7'h01, 8'h02, 8'h02, 1'h0, 2'h2},
        '{7'h01, 8'h07, 8'h07, 1'h0, 2'h3}};

    ssc_mode_supply #(.RESET_PULSE_CYCLES(20), .CNT_W(16)) dut (.clk(clk), .reset(reset), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .dev_mode_pin(dev_mode_pin),
        .overvoltage_pin(overvoltage_pin), .overtemp_pin(overtemp_pin), .restart_request_pin(restart_request_pin),
        .failsafe_select_pin(failsafe_select_pin), .flag_clear(flag_clear), .reset_output_low(reset_output_low),
        .secondary_supply_on(secondary_supply_on), .reset_threshold_select(reset_threshold_select),
        .primary_overvoltage_flag(primary_overvoltage_flag), .spi_failure_flag(spi_failure_flag),
        .mode_state(mode_state));
    ssc_host host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({d, 1'h1, a}, 16, rx);
    endtask

    task automatic rd(input logic [6:0] a);
        host.xfer({8'h00, 1'h0, a}, 16, rx);
        rb = rx[15:8];
    endtask

    // bounded wait; running out ends the run
    task automatic wait_state(input logic [2:0] st);
        int i;
        for (i = 0; i < 200 && mode_state !== st; i++) @(negedge clk);
        check("mode_state", st, mode_state);
        if (mode_state !== st) summarize();
    endtask

    task automatic pulse(ref logic p);
        p = 1'h1;
        repeat (6) @(negedge clk);
        p = 1'h0;
        repeat (8) @(negedge clk);
    endtask

    task automatic clr();
        flag_clear = 1'h1;
        @(negedge clk);
        flag_clear = 1'h0;
        @(negedge clk);
    endtask

    task automatic do_reset();
        reset = 1'h1;
        repeat (12) @(negedge clk);
        check("reset out", 0, reset_output_low);
        check("supply", 0, secondary_supply_on);
        check("mode_state", 0, mode_state);
        check("flags", 0, {primary_overvoltage_flag, spi_failure_flag});
        reset = 1'h0;
        repeat (8) @(negedge clk);
    endtask

    // free-running system clock
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial begin
        {dev_mode_pin, overvoltage_pin, overtemp_pin, restart_request_pin, failsafe_select_pin, flag_clear} = 6'h00;
        for (int i = 0; i < 128; i++) shadow[i] = 8'h00;
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            check("old data", shadow[rows[i].a], rx[15:8]);
            check("status", 0, rx[7:0]);
            shadow[rows[i].a] = rows[i].keep;
            rd(rows[i].a);
            check("read back", rows[i].keep, rb);
            check("supply", rows[i].sup, secondary_supply_on);
            check("threshold", rows[i].thr, reset_threshold_select);
            $display("row %0d done", i);
        end
        check("mode_state", 1, mode_state);
        pulse(overvoltage_pin);
        wait_state(3'h4);
        check("reset out", 0, reset_output_low);
        wait_state(3'h1);
        check("ov flag", 1, primary_overvoltage_flag);
        rd(7'h01);
        check("restart value", 8'h03, rb);
        clr();
        failsafe_select_pin = 1'h1;
        wr(7'h01, 8'h1c);
        check("supply", 1, secondary_supply_on);
        pulse(overvoltage_pin);
        wait_state(3'h5);
        check("supply", 0, secondary_supply_on);
        pulse(restart_request_pin);
        wait_state(3'h1);
        rd(7'h01);
        check("restart value", 8'h00, rb);
        failsafe_select_pin = 1'h0;
        $display("test restart and fail-safe done");
        clr();
        wr(7'h01, 8'h01);
        pulse(overvoltage_pin);
        repeat (30) @(negedge clk);
        check("mode_state", 1, mode_state);
        check("ov flag", 1, primary_overvoltage_flag);
        wr(7'h01, 8'h18);
        check("supply", 1, secondary_supply_on);
        pulse(overtemp_pin);
        rd(7'h01);
        check("after overtemp", 8'h00, rb);
        check("supply", 0, secondary_supply_on);
        $display("test overvoltage and overtemperature done");
        clr();
        wr(7'h01, 8'h80);
        check("mode_state", 3, mode_state);
        wr(7'h01, 8'h40);
        rd(7'h01);
        check("stop kept", 8'h80, rb);
        check("fail flag", 0, spi_failure_flag);
        wr(7'h01, 8'h0b);
        rd(7'h01);
        check("stop to normal", 8'h00, rb);
        check("mode_state", 1, mode_state);
        check("fail flag", 1, spi_failure_flag);
        clr();
        host.xfer(16'h0281, 12, rx);
        check("fail flag", 1, spi_failure_flag);
        rd(7'h01);
        check("short frame", 8'h00, rb);
        $display("test stop moves and short frame done");
        clr();
        wr(7'h02, 8'h40);
        wr(7'h01, 8'hc3);
        lows = 0;
        repeat (30) begin
            @(negedge clk);
            lows += !reset_output_low;
        end
        check("held reset", 0, lows);
        check("mode_state", 0, mode_state);
        rd(7'h01);
        check("soft reset value", 8'h00, rb);
        rd(7'h02);
        check("config cleared", 8'h00, rb);
        wr(7'h01, 8'hc0);
        lows = 0;
        repeat (30) begin
            @(negedge clk);
            lows += !reset_output_low;
        end
        check("pulsed reset", 1, lows > 0);
        wr(7'h01, 8'h00);
        wr(7'h01, 8'h58);
        check("mode_state", 2, mode_state);
        check("supply", 1, secondary_supply_on);
        $display("test soft reset and sleep done");
        dev_mode_pin = 1'h1;
        do_reset();
        rd(7'h01);
        check("dev power-on", 8'h18, rb);
        check("supply", 1, secondary_supply_on);
        wr(7'h01, 8'hc0);
        rd(7'h01);
        check("dev soft reset", 8'h00, rb);
        check("supply", 0, secondary_supply_on);
        $display("test development mode done");
        summarize();
    end
endmodule // tb

// ==== hdl/ssc_map.vh ====
/*
 * Constants for the mode-and-supply control block: control-space address map,
 * field positions, reset values, mode and supply codes, timing figures.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

// seven-bit control-space addresses
`define SSC_ADDR_MODE_SUPPLY 7'h01
`define SSC_ADDR_HW_CFG0 7'h02
`define SSC_ADDR_WDOG 7'h03
`define SSC_ADDR_BUS0 7'h04
`define SSC_ADDR_WAKE_INT 7'h06
`define SSC_ADDR_WAKE_EXT 7'h07
`define SSC_ADDR_WAKE_PULL 7'h08
`define SSC_ADDR_BUS3 7'h0b
`define SSC_ADDR_TIMER 7'h0c
`define SSC_ADDR_HW_CFG1 7'h0e
`define SSC_ADDR_HW_CFG2 7'h0f
`define SSC_ADDR_GPIO 7'h17
`define SSC_ADDR_PWM_DUTY 7'h18
`define SSC_ADDR_PWM_FREQ 7'h1c
`define SSC_ADDR_HW_CFG3 7'h1d
`define SSC_ADDR_SCRATCH_LO 7'h1e
`define SSC_ADDR_SCRATCH_HI 7'h1f

// mode-and-supply register fields
`define SSC_MODE_HI 7
`define SSC_MODE_LO 6
`define SSC_RSVD_BIT 5
`define SSC_SUPPLY_HI 4
`define SSC_SUPPLY_LO 3
`define SSC_OV_EN_BIT 2
`define SSC_THR_HI 1
`define SSC_THR_LO 0
`define SSC_MODE_SUPPLY_RESET 8'h00
`define SSC_RESTART_KEEP_MASK 8'h03
`define SSC_RSVD_MASK 8'hdf
`define SSC_SOFT_RST_CFG_BIT 6

// mode field codes
`define SSC_MODE_NORMAL 2'h0
`define SSC_MODE_SLEEP 2'h1
`define SSC_MODE_STOP 2'h2
`define SSC_MODE_SOFT_RESET 2'h3

// secondary supply field codes
`define SSC_SUP_OFF 2'h0
`define SSC_SUP_NORMAL 2'h1
`define SSC_SUP_NORMAL_STOP 2'h2
`define SSC_SUP_ALWAYS 2'h3

// frame layout: bits 6:0 address, bit 7 write, bits 15:8 data
`define SSC_FRAME_BITS 5'h10
`define SSC_ADDR_BITS 5'h08
`define SSC_WRITE_BIT 7

// synchroniser vector order {fs, rr, ot, ov, dev, mosi, cs_n, sclk}
`define SSC_SYNC_RESET 8'h02

// timing
`define SSC_CLK_PERIOD_NS 10
`define SSC_RESET_PULSE_NS 10000
`define SSC_POR_WAIT_START 2'h3
`define SSC_POR_LOAD_STEP 2'h1

`endif

// ==== hdl/ssc_mode_supply.v ====
/*
 * Mode-and-supply control with the general control register space, reached over
 * a 16-bit serial frame (LSB first, shift on rising, sample on falling clock).
 * Assumes all pins are asynchronous to clk and the serial clock is far slower.
 */
`timescale 1ns/1ps
`include "ssc_map.vh"
module ssc_mode_supply #(
    parameter RESET_PULSE_CYCLES = `SSC_RESET_PULSE_NS / `SSC_CLK_PERIOD_NS,
    parameter CNT_W = 16
) (
    input wire clk,
    input wire reset,
    input wire spi_clk,
    input wire spi_cs_n,
    input wire spi_mosi,
    output reg spi_miso,
    input wire dev_mode_pin,
    input wire overvoltage_pin,
    input wire overtemp_pin,
    input wire restart_request_pin,
    input wire failsafe_select_pin,
    input wire flag_clear,
    output reg reset_output_low,
    output reg secondary_supply_on,
    output reg [1:0] reset_threshold_select,
    output reg primary_overvoltage_flag,
    output reg spi_failure_flag,
    output reg [2:0] mode_state
);
    localparam ST_INIT = 3'h0;
    localparam ST_NORMAL = 3'h1;
    localparam ST_SLEEP = 3'h2;
    localparam ST_STOP = 3'h3;
    localparam ST_RESTART = 3'h4;
    localparam ST_FAILSAFE = 3'h5;

    reg [7:0] sync1_reg;
    reg [7:0] sync2_reg;
    reg [7:0] prev_reg;
    reg [15:0] rx_reg;
    reg [4:0] bit_cnt_reg;
    reg rd_pending_reg;
    reg [7:0] tx_hi_reg;
    reg [7:0] mode_supply_reg;
    reg [7:0] mode_supply_next;
    reg [2:0] state_next;
    reg soft_cfg_reg;
    reg [CNT_W-1:0] pulse_cnt_reg;
    reg [CNT_W-1:0] pulse_cnt_next;
    reg [1:0] por_wait_reg;
    reg soft_reset;
    reg stop_to_normal;
    reg supply_on_next;
    wire [7:0] mem_rd_data;
    wire [7:0] sync_now;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_start;
    wire cs_end;
    wire frame_ok;
    wire frame_bad;
    wire frame_write;
    wire [6:0] frame_addr;
    wire [7:0] frame_data;
    wire ms_write;
    wire listed;
    wire ov_rise;
    wire ot_rise;
    wire rr_rise;
    wire restart_entry;
    wire failsafe_entry;
    wire [7:0] status_byte;
    wire [7:0] rd_byte;

    // pin synchronisers; only the second stage and its delayed copy feed logic
    always @(posedge clk) begin
        if (reset) begin
            sync1_reg <= `SSC_SYNC_RESET;
            sync2_reg <= `SSC_SYNC_RESET;
            prev_reg <= `SSC_SYNC_RESET;
        end else begin
            sync1_reg <= {failsafe_select_pin, restart_request_pin, overtemp_pin, overvoltage_pin,
                          dev_mode_pin, spi_mosi, spi_cs_n, spi_clk};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign sync_now = sync2_reg;
    assign sclk_rise = !sync_now[1] && sync_now[0] && !prev_reg[0];
    assign sclk_fall = !sync_now[1] && !sync_now[0] && prev_reg[0];
    assign cs_start = !sync_now[1] && prev_reg[1];
    assign cs_end = sync_now[1] && !prev_reg[1];
    assign ov_rise = sync_now[4] && !prev_reg[4];
    assign ot_rise = sync_now[5] && !prev_reg[5];
    assign rr_rise = sync_now[6] && !prev_reg[6];

    // frame decode: 16 bits or more, extra bits ignored; a shorter frame is dropped and flagged
    assign frame_ok = cs_end && bit_cnt_reg == `SSC_FRAME_BITS;
    assign frame_bad = cs_end && bit_cnt_reg != `SSC_FRAME_BITS;
    assign frame_write = frame_ok && rx_reg[`SSC_WRITE_BIT];
    assign frame_addr = rx_reg[6:0];
    assign frame_data = rx_reg[15:8];
    assign ms_write = frame_write && frame_addr == `SSC_ADDR_MODE_SUPPLY;

    // listed plain read/write registers; anything else but the mode-and-supply register is unmapped
    assign listed = frame_addr == `SSC_ADDR_HW_CFG0 || frame_addr == `SSC_ADDR_WDOG ||
                    frame_addr == `SSC_ADDR_BUS0 || frame_addr == `SSC_ADDR_WAKE_INT ||
                    frame_addr == `SSC_ADDR_WAKE_EXT || frame_addr == `SSC_ADDR_WAKE_PULL ||
                    frame_addr == `SSC_ADDR_BUS3 || frame_addr == `SSC_ADDR_TIMER ||
                    frame_addr == `SSC_ADDR_HW_CFG1 || frame_addr == `SSC_ADDR_HW_CFG2 ||
                    frame_addr == `SSC_ADDR_GPIO || frame_addr == `SSC_ADDR_PWM_DUTY ||
                    frame_addr == `SSC_ADDR_PWM_FREQ || frame_addr == `SSC_ADDR_HW_CFG3 ||
                    frame_addr == `SSC_ADDR_SCRATCH_LO || frame_addr == `SSC_ADDR_SCRATCH_HI;

    // read mux for the data byte; unmapped reads give zero
    assign rd_byte = (frame_addr == `SSC_ADDR_MODE_SUPPLY) ? (mode_supply_reg & `SSC_RSVD_MASK) :
                     listed ? mem_rd_data : 8'h00;
    assign status_byte = {6'h00, primary_overvoltage_flag, spi_failure_flag};

    // overvoltage enters restart or fail-safe only with the enable bit; select pin picks the target
    assign restart_entry = (ov_rise && mode_supply_reg[`SSC_OV_EN_BIT] && !sync_now[7]) || rr_rise;
    assign failsafe_entry = ov_rise && mode_supply_reg[`SSC_OV_EN_BIT] && sync_now[7];

    ssc_regmem #(
        .WIDTH(8),
        .DEPTH(32),
        .AW(5)
    ) u_regmem (
        .clk(clk),
        .reset(reset),
        .clear(soft_reset),
        .wr_en(frame_write && listed),
        .wr_addr(frame_addr[4:0]),
        .wr_data(frame_data),
        .rd_addr(rx_reg[4:0]),
        .rd_data(mem_rd_data)
    );

    // serial shift engine; the data byte is snapshotted before any write lands
    always @(posedge clk) begin
        if (reset) begin
            rx_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            rd_pending_reg <= 1'b0;
            tx_hi_reg <= 8'h00;
            spi_miso <= 1'b0;
        end else begin
            if (cs_start) begin
                bit_cnt_reg <= 5'h00;
                rd_pending_reg <= 1'b0;
            end else if (sclk_fall && bit_cnt_reg != `SSC_FRAME_BITS) begin
                rx_reg[bit_cnt_reg[3:0]] <= sync_now[2];
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                rd_pending_reg <= (bit_cnt_reg + 5'h01) == `SSC_ADDR_BITS;
            end else begin
                rd_pending_reg <= 1'b0;
            end
            // memory read data is valid one cycle after the address settles
            if (rd_pending_reg) begin
                tx_hi_reg <= rd_byte;
            end
            if (sclk_rise) begin
                if (bit_cnt_reg < `SSC_ADDR_BITS) begin
                    spi_miso <= status_byte[bit_cnt_reg[2:0]];
                end else begin
                    spi_miso <= tx_hi_reg[bit_cnt_reg[2:0]];
                end
            end
        end
    end

    // next value of the mode-and-supply register and of the device state
    always @* begin
        mode_supply_next = mode_supply_reg;
        state_next = mode_state;
        soft_reset = 1'b0;
        stop_to_normal = 1'b0;
        if (restart_entry) begin
            // threshold survives, everything else goes to normal/off/disabled
            mode_supply_next = mode_supply_reg & `SSC_RESTART_KEEP_MASK;
            state_next = ST_RESTART;
        end else if (failsafe_entry) begin
            state_next = ST_FAILSAFE;
        end else if (ms_write) begin
            case (frame_data[`SSC_MODE_HI:`SSC_MODE_LO])
                `SSC_MODE_SOFT_RESET: begin
                    mode_supply_next = `SSC_MODE_SUPPLY_RESET;
                    soft_reset = 1'b1;
                    state_next = ST_INIT;
                end
                `SSC_MODE_SLEEP: begin
                    if (mode_state != ST_STOP) begin
                        mode_supply_next = frame_data & `SSC_RSVD_MASK;
                        state_next = ST_SLEEP;
                    end
                end
                `SSC_MODE_STOP: begin
                    mode_supply_next = frame_data & `SSC_RSVD_MASK;
                    state_next = ST_STOP;
                end
                default: begin
                    if (mode_state == ST_STOP) begin
                        // only the mode field moves; the rest of the write is dropped
                        mode_supply_next = {`SSC_MODE_NORMAL, mode_supply_reg[5:0]};
                        stop_to_normal = 1'b1;
                    end else begin
                        mode_supply_next = frame_data & `SSC_RSVD_MASK;
                    end
                    state_next = ST_NORMAL;
                end
            endcase
        end else if (mode_state == ST_RESTART && pulse_cnt_reg == {CNT_W{1'b0}}) begin
            state_next = ST_NORMAL;
        end
        if (ot_rise) begin
            mode_supply_next[`SSC_SUPPLY_HI:`SSC_SUPPLY_LO] = `SSC_SUP_OFF;
        end
        // development strap is caught once the synchroniser has settled after reset
        if (por_wait_reg == `SSC_POR_LOAD_STEP && sync_now[3]) begin
            mode_supply_next[`SSC_SUPPLY_HI:`SSC_SUPPLY_LO] = `SSC_SUP_ALWAYS;
        end
    end

    // reset output pulse length; soft reset only pulses with config bit clear
    always @* begin
        pulse_cnt_next = pulse_cnt_reg;
        if ((soft_reset && !soft_cfg_reg) || restart_entry) begin
            pulse_cnt_next = RESET_PULSE_CYCLES[CNT_W-1:0];
        end else if (pulse_cnt_reg != {CNT_W{1'b0}}) begin
            pulse_cnt_next = pulse_cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // supply switch decision from next field and next state
    always @* begin
        case (mode_supply_next[`SSC_SUPPLY_HI:`SSC_SUPPLY_LO])
            `SSC_SUP_NORMAL: supply_on_next = state_next == ST_NORMAL;
            `SSC_SUP_NORMAL_STOP: supply_on_next = state_next == ST_NORMAL || state_next == ST_STOP;
            `SSC_SUP_ALWAYS: supply_on_next = !(state_next == ST_RESTART || state_next == ST_FAILSAFE ||
                                                (state_next == ST_INIT && !sync_now[3]));
            default: supply_on_next = 1'b0;
        endcase
    end

    // state, register and output flops
    always @(posedge clk) begin
        if (reset) begin
            mode_supply_reg <= `SSC_MODE_SUPPLY_RESET;
            mode_state <= ST_INIT;
            soft_cfg_reg <= 1'b0;
            pulse_cnt_reg <= RESET_PULSE_CYCLES[CNT_W-1:0];
            por_wait_reg <= `SSC_POR_WAIT_START;
            reset_output_low <= 1'b0;
            secondary_supply_on <= 1'b0;
            reset_threshold_select <= 2'h0;
            primary_overvoltage_flag <= 1'b0;
            spi_failure_flag <= 1'b0;
        end else begin
            mode_supply_reg <= mode_supply_next;
            mode_state <= state_next;
            pulse_cnt_reg <= pulse_cnt_next;
            if (por_wait_reg != 2'h0) begin
                por_wait_reg <= por_wait_reg - 2'h1;
            end
            // shadow of the soft-reset config bit, cleared by soft reset itself
            if (soft_reset) begin
                soft_cfg_reg <= 1'b0;
            end else if (frame_write && frame_addr == `SSC_ADDR_HW_CFG0) begin
                soft_cfg_reg <= frame_data[`SSC_SOFT_RST_CFG_BIT];
            end
            reset_output_low <= pulse_cnt_next == {CNT_W{1'b0}};
            secondary_supply_on <= supply_on_next;
            reset_threshold_select <= mode_supply_next[`SSC_THR_HI:`SSC_THR_LO];
            // sticky flags: a new event in the clear cycle wins
            if (ov_rise) begin
                primary_overvoltage_flag <= 1'b1;
            end else if (flag_clear) begin
                primary_overvoltage_flag <= 1'b0;
            end
            if (stop_to_normal || frame_bad) begin
                spi_failure_flag <= 1'b1;
            end else if (flag_clear) begin
                spi_failure_flag <= 1'b0;
            end
        end
    end
endmodule // ssc_mode_supply

// ==== hdl/ssc_regmem.v ====
/*
 * Small register store for the plain read/write control registers.
 * Assumes one clock domain, synchronous active-high reset; read data is registered.
 */
`timescale 1ns/1ps
module ssc_regmem #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire reset,
    input wire clear,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    wire [WIDTH-1:0] entry [0:DEPTH-1];

    // one storage word per entry; soft reset returns all to zero
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
            // entry index at address width, so the compare needs no select on the genvar
            localparam [AW-1:0] IDX = i;
            reg [WIDTH-1:0] word_reg;
            always @(posedge clk) begin
                if (reset || clear) begin
                    word_reg <= {WIDTH{1'b0}};
                end else if (wr_en && wr_addr == IDX) begin
                    word_reg <= wr_data;
                end
            end
            assign entry[i] = word_reg;
        end
    endgenerate

    // registered read port
    always @(posedge clk) begin
        if (reset) begin
            rd_data <= {WIDTH{1'b0}};
        end else begin
            rd_data <= entry[rd_addr];
        end
    end
endmodule // ssc_regmem
